// file: verilog/rhb_pkg.sv
// Purpose: constants shared by the resonant half-bridge gate generator
// Assumes: clk_sys at 100 MHz, sense levels arrive as millivolt codes from a converter on clk_sys
// Notes: thresholds without a printed value are plain defaults
// Functional notes
// R01: both gates come from a divide-by-two stage: half duty, opposite phase
// R02: a fixed 380 ns dead interval separates one gate off from the other on
// R03: gate on-time is the ramp charge phase; discharge phase forms the dead interval
// R04: charge rate is base plus feedback plus overcurrent plus soft-start term
// R05: minimum-frequency pin held at 1.5 V; one tenth of its current is the base
// R06: overcurrent term never exceeds three times the base term
// R07: soft-start term never exceeds about 3.4 times the base term
// R08: total charge rate never exceeds five times the base term
// R09: total at most 3x base normally, about 4x under fault, 4.43x in soft start; code lets both reach the 5x cap with the feedback term at full
// R10: higher feedback lowers frequency; only 0.9 V to 3.9 V affects the feedback term
// R11: feedback below burst-off for the blanking time stops gating until above burst-on
// R12: operate from supply 12 V rising until below 11 V falling
// R13: soft start lasts 32 ms in 32 equal steps, soft-start term lowering each step
// R14: overload detection is disabled during soft start
// R15: current sense above 0.8 V raises frequency; below 0.75 V it gradually returns
// R16: overcurrent term ramps to maximum in 1.5 ms and back down symmetrically
// R17: current sense above the high level latches both gates off at once
// R18: mains sense below its on-threshold stops switching; restart when back in range
// R19: every start, restart included, is a full soft start with mains and supply good
// R20: all intervals counted from clk_sys; soft-start steps of equal length
// R21: high overcurrent latch holds, gates low, until supply drops below off level
package rhb_pkg;
    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int DEAD_TIME_NS = 380;
    localparam int DEAD_CYC = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SS_TOTAL_MS = 32;
    localparam int SS_STEPS = 32;
    localparam int SS_STEP_CYC = (SS_TOTAL_MS * 1000000) / (CLK_PERIOD_NS * SS_STEPS);
    localparam int OC_RAMP_US = 1500;
    localparam int OC_RAMP_CYC = (OC_RAMP_US * 1000) / CLK_PERIOD_NS;
    localparam int OC_LVL_MAX = 256;
    localparam int OC_TICK_CYC = OC_RAMP_CYC / OC_LVL_MAX;
    localparam int BURST_BLANK_CYC = 1000;
    localparam int OLP_BLANK_MS = 20;
    localparam int OLP_BLANK_CYC = (OLP_BLANK_MS * 1000000) / CLK_PERIOD_NS;
    // ----------------------------------------------------------------
    // levels in millivolts
    // ----------------------------------------------------------------
    localparam logic [11:0] FMIN_PIN_MV = 12'h5dc;
    localparam logic [11:0] FB_MIN_MV = 12'h384;
    localparam logic [11:0] FB_MAX_MV = 12'hf3c;
    localparam logic [11:0] CS_LOW_MV = 12'h320;
    localparam logic [11:0] CS_REL_MV = 12'h2ee;
    localparam logic [11:0] CS_HIGH_MV = 12'h640;
    localparam logic [11:0] BURST_OFF_MV = 12'h258;
    localparam logic [11:0] BURST_ON_MV = 12'h2bc;
    localparam logic [11:0] FB_OLP_MV = 12'hfa0;
    // ----------------------------------------------------------------
    // oscillator scaling
    // ----------------------------------------------------------------
    localparam logic [17:0] RAMP_TOP = 18'h0c000;
    localparam logic [31:0] BASE_MUL = 32'h000000cd;
    localparam int BASE_SHIFT = 11;
    localparam logic [31:0] FB_MUL = 32'h0000000b;
    localparam int FB_SHIFT = 14;
    localparam logic [31:0] SS_MUL = 32'h00000007;
    localparam int SS_SHIFT = 6;
    localparam logic [31:0] SS_CAP_MUL = 32'h00000366;
    localparam int CAP_SHIFT = 8;
    localparam logic [4:0] SS_LAST_STEP = 5'h1f;
    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {ST_OFF, ST_WAIT, ST_SOFT, ST_RUN, ST_BURST, ST_LATCH} rhb_state_t;
endpackage

// file: verilog/rhb_ctrl.sv
// Purpose: gate generation and protection sequencing for a resonant half-bridge
// Assumes: supply and mains comparator bits are asynchronous pins; mv codes are on clk_sys
// Notes: extended overload timer and mains restart counter are not part of this block
`timescale 1ns/1ns
module rhb_ctrl #(
    parameter int SS_STEP_CYC = rhb_pkg::SS_STEP_CYC,
    parameter int OC_RAMP_CYC = rhb_pkg::OC_RAMP_CYC,
    parameter int OLP_BLANK_CYC = rhb_pkg::OLP_BLANK_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // comparator pins
    input wire logic supply_above_on,
    input wire logic supply_above_off,
    input wire logic mains_above_on,
    // sense codes: feedback and current sense in millivolts, minimum-frequency pin current
    input wire logic [11:0] feedback_input,
    input wire logic [11:0] cs_mv,
    input wire logic [11:0] fmin_current,
    // gate drive
    output logic high_side_gate,
    output logic low_side_gate,
    // status
    output logic [11:0] fmin_hold_mv,
    output logic soft_start_active,
    output logic ocp_latched,
    output logic overload_detect
);
    localparam int OC_TICK = OC_RAMP_CYC / rhb_pkg::OC_LVL_MAX;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] pin_s1_r;
    logic [2:0] pin_s2_r;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pin_s1_r <= 3'h0;
            pin_s2_r <= 3'h0;
        end else begin
            pin_s1_r <= {mains_above_on, supply_above_off, supply_above_on};
            pin_s2_r <= pin_s1_r;
        end
    end
    logic sup_on;
    logic sup_off_ok;
    logic mains_ok;
    assign sup_on = pin_s2_r[0];
    assign sup_off_ok = pin_s2_r[1];
    assign mains_ok = pin_s2_r[2];

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    rhb_pkg::rhb_state_t state_r, state_nxt;
    logic powered_r, powered_nxt;
    logic latch_r, latch_nxt;
    logic [16:0] ss_cnt_r, ss_cnt_nxt;
    logic [4:0] ss_step_r, ss_step_nxt;
    logic [15:0] burst_cnt_r, burst_cnt_nxt;
    logic [20:0] olp_cnt_r, olp_cnt_nxt;
    logic olp_r, olp_nxt;
    logic [9:0] oc_tick_r, oc_tick_nxt;
    logic [8:0] oc_lvl_r, oc_lvl_nxt;
    logic cs_high;
    assign cs_high = cs_mv > rhb_pkg::CS_HIGH_MV;

    always_comb begin
        powered_nxt = powered_r;
        latch_nxt = latch_r;
        state_nxt = state_r;
        ss_cnt_nxt = ss_cnt_r;
        ss_step_nxt = ss_step_r;
        burst_cnt_nxt = 16'h0;
        olp_cnt_nxt = 21'h0;
        olp_nxt = olp_r;
        oc_tick_nxt = oc_tick_r;
        oc_lvl_nxt = oc_lvl_r;
        // hysteresis: off wins only when below the lower level
        if (!sup_off_ok) begin
            powered_nxt = 1'b0; // R12
        end else if (sup_on) begin
            powered_nxt = 1'b1; // R12
        end
        // set wins over the supply clear
        if (cs_high) begin
            latch_nxt = 1'b1; // R17
        end else if (!sup_off_ok) begin
            latch_nxt = 1'b0; // R21
        end
        unique case (state_r)
            rhb_pkg::ST_OFF: begin
                if (powered_nxt) begin
                    state_nxt = rhb_pkg::ST_WAIT;
                end
            end
            rhb_pkg::ST_WAIT: begin
                if (mains_ok) begin
                    state_nxt = rhb_pkg::ST_SOFT; // R19
                    ss_cnt_nxt = 17'h0;
                    ss_step_nxt = 5'h0;
                end
            end
            rhb_pkg::ST_SOFT: begin
                if (ss_cnt_r == 17'(SS_STEP_CYC - 1)) begin
                    ss_cnt_nxt = 17'h0; // R20
                    if (ss_step_r == rhb_pkg::SS_LAST_STEP) begin
                        state_nxt = rhb_pkg::ST_RUN; // R13
                    end else begin
                        ss_step_nxt = ss_step_r + 5'h1; // R13
                    end
                end else begin
                    ss_cnt_nxt = ss_cnt_r + 17'h1;
                end
            end
            rhb_pkg::ST_RUN: begin
                if (feedback_input < rhb_pkg::BURST_OFF_MV) begin
                    burst_cnt_nxt = burst_cnt_r + 16'h1;
                    if (burst_cnt_r == 16'(rhb_pkg::BURST_BLANK_CYC - 1)) begin
                        state_nxt = rhb_pkg::ST_BURST; // R11
                    end
                end
                // only outside soft start does high feedback count
                if (feedback_input > rhb_pkg::FB_OLP_MV) begin
                    olp_cnt_nxt = olp_cnt_r + 21'h1; // R14
                    if (olp_cnt_r == 21'(OLP_BLANK_CYC - 1)) begin
                        olp_nxt = 1'b1;
                    end
                end
            end
            rhb_pkg::ST_BURST: begin
                if (feedback_input > rhb_pkg::BURST_ON_MV) begin
                    state_nxt = rhb_pkg::ST_RUN; // R11
                end
            end
            rhb_pkg::ST_LATCH: begin
            end
        endcase
        if (state_r != rhb_pkg::ST_OFF && state_r != rhb_pkg::ST_LATCH && !mains_ok) begin
            state_nxt = rhb_pkg::ST_WAIT; // R18
        end
        if (state_nxt == rhb_pkg::ST_WAIT) begin
            olp_nxt = 1'b0;
        end
        if (latch_nxt) begin
            state_nxt = rhb_pkg::ST_LATCH; // R21
        end
        if (!powered_nxt) begin
            state_nxt = rhb_pkg::ST_OFF; // R12
            olp_nxt = 1'b0;
        end
        // overcurrent level walks one step per tick, up or down at the same pace
        if (state_nxt == rhb_pkg::ST_OFF) begin
            oc_tick_nxt = 10'h0;
            oc_lvl_nxt = 9'h0;
        end else if (oc_tick_r == 10'(OC_TICK - 1)) begin
            oc_tick_nxt = 10'h0; // R20
            if (cs_mv > rhb_pkg::CS_LOW_MV && oc_lvl_r != 9'(rhb_pkg::OC_LVL_MAX)) begin
                oc_lvl_nxt = oc_lvl_r + 9'h1; // R15 R16
            end else if (cs_mv < rhb_pkg::CS_REL_MV && oc_lvl_r != 9'h0) begin
                oc_lvl_nxt = oc_lvl_r - 9'h1; // R15 R16
            end
        end else begin
            oc_tick_nxt = oc_tick_r + 10'h1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_r <= rhb_pkg::ST_OFF;
            powered_r <= 1'b0;
            latch_r <= 1'b0;
            ss_cnt_r <= 17'h0;
            ss_step_r <= 5'h0;
            burst_cnt_r <= 16'h0;
            olp_cnt_r <= 21'h0;
            olp_r <= 1'b0;
            oc_tick_r <= 10'h0;
            oc_lvl_r <= 9'h0;
        end else begin
            state_r <= state_nxt;
            powered_r <= powered_nxt;
            latch_r <= latch_nxt;
            ss_cnt_r <= ss_cnt_nxt;
            ss_step_r <= ss_step_nxt;
            burst_cnt_r <= burst_cnt_nxt;
            olp_cnt_r <= olp_cnt_nxt;
            olp_r <= olp_nxt;
            oc_tick_r <= oc_tick_nxt;
            oc_lvl_r <= oc_lvl_nxt;
        end
    end

    // ----------------------------------------------------------------
    // charge rate
    // ----------------------------------------------------------------
    logic [31:0] base_w;
    logic [31:0] fb_w;
    logic [31:0] oc_w;
    logic [31:0] ss_w;
    logic [31:0] sum_w;
    logic [31:0] cap_w;
    logic [17:0] rate;
    logic [11:0] fb_clamp;
    always_comb begin
        // one tenth of the pin current, multiply-shift to avoid a divider
        base_w = (32'(fmin_current) * rhb_pkg::BASE_MUL) >> rhb_pkg::BASE_SHIFT; // R05
        fb_clamp = feedback_input;
        if (fb_clamp < rhb_pkg::FB_MIN_MV) begin
            fb_clamp = rhb_pkg::FB_MIN_MV; // R10
        end else if (fb_clamp > rhb_pkg::FB_MAX_MV) begin
            fb_clamp = rhb_pkg::FB_MAX_MV; // R10
        end
        // span of 3000 mV gives twice the base, so normal total tops near 3x
        fb_w = (base_w * 32'(rhb_pkg::FB_MAX_MV - fb_clamp) * rhb_pkg::FB_MUL) >> rhb_pkg::FB_SHIFT; // R10 R09
        oc_w = (base_w * 32'h3 * 32'(oc_lvl_r)) >> rhb_pkg::CAP_SHIFT; // R06 R16
        if (oc_w > base_w * 32'h3) begin
            oc_w = base_w * 32'h3; // R06
        end
        ss_w = 32'h0;
        if (state_r == rhb_pkg::ST_SOFT) begin
            ss_w = (base_w * 32'(rhb_pkg::SS_LAST_STEP - ss_step_r) * rhb_pkg::SS_MUL) >> rhb_pkg::SS_SHIFT; // R13
        end
        cap_w = (base_w * rhb_pkg::SS_CAP_MUL) >> rhb_pkg::CAP_SHIFT;
        if (ss_w > cap_w) begin
            ss_w = cap_w; // R07
        end
        sum_w = base_w + fb_w + oc_w + ss_w; // R04
        if (sum_w > base_w * 32'h5) begin
            sum_w = base_w * 32'h5; // R08
        end
        if (sum_w == 32'h0) begin
            sum_w = 32'h1;
        end
        rate = sum_w[17:0];
    end

    // ----------------------------------------------------------------
    // oscillator and divide-by-two
    // ----------------------------------------------------------------
    logic osc_en;
    logic charging_r, charging_nxt;
    logic phase_r, phase_nxt;
    logic [17:0] ramp_r, ramp_nxt;
    logic [5:0] dead_r, dead_nxt;
    logic hi_gate_r, hi_gate_nxt;
    logic lo_gate_r, lo_gate_nxt;
    logic [18:0] ramp_sum;
    assign osc_en = (state_nxt == rhb_pkg::ST_SOFT || state_nxt == rhb_pkg::ST_RUN);
    assign ramp_sum = {1'b0, ramp_r} + {1'b0, rate};

    always_comb begin
        charging_nxt = charging_r;
        phase_nxt = phase_r;
        ramp_nxt = ramp_r;
        dead_nxt = dead_r;
        if (!osc_en) begin
            // gates drop at once and park in the dead phase, so a quick restart
            // still waits a full dead interval and opens on the high side
            charging_nxt = 1'b0; // R17 R11 R18
            phase_nxt = 1'b1; // R01
            ramp_nxt = 18'h0;
            if (charging_r) begin
                dead_nxt = 6'h0; // R02
            end else if (dead_r != 6'(rhb_pkg::DEAD_CYC - 1)) begin
                dead_nxt = dead_r + 6'h1; // R02 R20
            end
        end else if (charging_r) begin
            if (ramp_sum >= {1'b0, rhb_pkg::RAMP_TOP}) begin
                charging_nxt = 1'b0; // R03
                ramp_nxt = 18'h0;
                dead_nxt = 6'h0;
            end else begin
                ramp_nxt = ramp_sum[17:0]; // R03 R04
            end
        end else if (dead_r == 6'(rhb_pkg::DEAD_CYC - 1)) begin
            charging_nxt = 1'b1; // R02
            phase_nxt = !phase_r; // R01
        end else begin
            dead_nxt = dead_r + 6'h1; // R02 R20
        end
        hi_gate_nxt = osc_en && charging_nxt && !phase_nxt; // R01
        lo_gate_nxt = osc_en && charging_nxt && phase_nxt; // R01
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            charging_r <= 1'b1;
            phase_r <= 1'b0;
            ramp_r <= 18'h0;
            dead_r <= 6'h0;
            hi_gate_r <= 1'b0;
            lo_gate_r <= 1'b0;
        end else begin
            charging_r <= charging_nxt;
            phase_r <= phase_nxt;
            ramp_r <= ramp_nxt;
            dead_r <= dead_nxt;
            hi_gate_r <= hi_gate_nxt;
            lo_gate_r <= lo_gate_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    logic [11:0] fmin_r;
    logic ss_act_r;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fmin_r <= rhb_pkg::FMIN_PIN_MV;
            ss_act_r <= 1'b0;
        end else begin
            fmin_r <= rhb_pkg::FMIN_PIN_MV; // R05
            ss_act_r <= (state_nxt == rhb_pkg::ST_SOFT);
        end
    end
    assign high_side_gate = hi_gate_r;
    assign low_side_gate = lo_gate_r;
    assign fmin_hold_mv = fmin_r;
    assign soft_start_active = ss_act_r;
    assign ocp_latched = latch_r;
    assign overload_detect = olp_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [7:0] gap_r;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            gap_r <= 8'hff;
        end else if (hi_gate_r || lo_gate_r) begin
            gap_r <= 8'h0;
        end else if (gap_r != 8'hff) begin
            gap_r <= gap_r + 8'h1;
        end
    end
    sequence s_hi_pulse;
        $fell(hi_gate_r);
    endsequence
    sequence s_lo_rise;
        $rose(lo_gate_r);
    endsequence
    AST_NO_OVERLAP: assert property (@(posedge clk_sys) disable iff (rst) !(hi_gate_r && lo_gate_r)) // R01
        else $error("both gates high");
    AST_DEAD_GAP: assert property (@(posedge clk_sys) disable iff (rst) ($rose(hi_gate_r) || $rose(lo_gate_r)) |-> // R02
        $past(gap_r) >= 8'(rhb_pkg::DEAD_CYC - 1)) else $error("dead interval too short");
    AST_HI_THEN_LO: assert property (@(posedge clk_sys) disable iff (rst) s_hi_pulse |-> !lo_gate_r [*8]) // R02
        else $error("low gate rose inside dead interval");
    AST_LO_AFTER_HI: assert property (@(posedge clk_sys) disable iff (rst) s_lo_rise |-> $past(hi_gate_r, 39)) // R01
        else $error("gates not alternating");
    AST_RATE_CAP: assert property (@(posedge clk_sys) disable iff (rst) 32'(rate) <= 32'h5 * base_w + 32'h1) // R08
        else $error("charge rate above five times base");
    AST_LATCH_GATES: assert property (@(posedge clk_sys) disable iff (rst) cs_high |=> !hi_gate_r && !lo_gate_r && latch_r) // R17
        else $error("gates not latched off");
    AST_LATCH_HOLD: assert property (@(posedge clk_sys) disable iff (rst) latch_r && sup_off_ok |=> latch_r) // R21
        else $error("latch released with supply good");
    AST_NO_OLP_SS: assert property (@(posedge clk_sys) disable iff (rst) $rose(olp_r) |-> $past(state_r) == rhb_pkg::ST_RUN) // R14
        else $error("overload flagged outside normal run");
    AST_MAINS_STOP: assert property (@(posedge clk_sys) disable iff (rst) !mains_ok |=> !hi_gate_r && !lo_gate_r) // R18
        else $error("switching with mains low");
    AST_START_SOFT: assert property (@(posedge clk_sys) disable iff (rst) state_r == rhb_pkg::ST_WAIT && // R19
        state_nxt != rhb_pkg::ST_WAIT && state_nxt != rhb_pkg::ST_OFF && state_nxt != rhb_pkg::ST_LATCH
        |-> state_nxt == rhb_pkg::ST_SOFT) else $error("start without soft start");
    AST_UVLO: assert property (@(posedge clk_sys) disable iff (rst) !sup_off_ok |=> state_r == rhb_pkg::ST_OFF) // R12
        else $error("running below supply off level");
endmodule // rhb_ctrl

// file: tb/rhb_sense_model.sv
// Purpose: sense networks and half-bridge switches facing rhb_ctrl
// Assumes: bench sets analog levels in millivolts, all on clk_sys
// Notes: sense paths are single registers, so each output is the bench level one clock late
`timescale 1ns/1ns
module rhb_sense_model #(
    parameter int MAINS_ON_MV = 1250
) (
    // clock
    input wire logic clk_sys,
    // analog levels from the bench
    input wire logic [15:0] supply_mv,
    input wire logic [15:0] mains_mv,
    input wire logic [11:0] fb_mv,
    input wire logic [11:0] cs_set_mv,
    // gates from the controller
    input wire logic high_side_gate,
    input wire logic low_side_gate,
    // comparator pins and sense codes
    output logic supply_above_on,
    output logic supply_above_off,
    output logic mains_above_on,
    output logic [11:0] feedback_input,
    output logic [11:0] cs_mv,
    // both switches on together: shoot-through in the bridge
    output logic overlap_seen
);
    // ----------------------------------------------------------------
    // comparators and registered sense
    // ----------------------------------------------------------------
    initial overlap_seen = 1'b0;
    always @(posedge clk_sys) begin
        supply_above_on <= supply_mv >= 16'h2ee0;
        supply_above_off <= supply_mv >= 16'h2af8;
        mains_above_on <= mains_mv > MAINS_ON_MV;
        feedback_input <= fb_mv;
        cs_mv <= cs_set_mv;
        if (high_side_gate === 1'b1 && low_side_gate === 1'b1) begin
            overlap_seen <= 1'b1;
        end
    end
endmodule // rhb_sense_model

// file: tb/rhb_ctrl_bench.sv
// Purpose: self-checking bench for rhb_ctrl
// Assumes: base term 100 from fmin_current 1000; short test counts
// Notes: on-times follow ceil(0xc000 / rate) with the chosen scaling
`timescale 1ns/1ns
module rhb_ctrl_bench;
    logic clk_sys, rst;
    logic [15:0] supply_mv, mains_mv;
    logic [11:0] fb_mv, cs_set_mv, fmin_current, fmin_hold_mv, w;
    logic sa_on, sa_off, m_on, gate_hi, gate_lo, ssa, overcurrent_protection, ovl, overlap;
    logic [11:0] fb_in, cs_in;
    int n_fail = 0;
    int total_checks = 0;
    // ----------------------------------------------------------------
    // clock, design and partner
    // ----------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    rhb_ctrl #(.SS_STEP_CYC(20), .OC_RAMP_CYC(2560), .OLP_BLANK_CYC(50)) uut (.clk_sys(clk_sys), .rst(rst),
        .supply_above_on(sa_on), .supply_above_off(sa_off), .mains_above_on(m_on), .feedback_input(fb_in),
        .cs_mv(cs_in), .fmin_current(fmin_current), .high_side_gate(gate_hi), .low_side_gate(gate_lo),
        .fmin_hold_mv(fmin_hold_mv), .soft_start_active(ssa), .ocp_latched(overcurrent_protection), .overload_detect(ovl));
    rhb_sense_model sense (.clk_sys(clk_sys), .supply_mv(supply_mv), .mains_mv(mains_mv), .fb_mv(fb_mv),
        .cs_set_mv(cs_set_mv), .high_side_gate(gate_hi), .low_side_gate(gate_lo), .supply_above_on(sa_on),
        .supply_above_off(sa_off), .mains_above_on(m_on), .feedback_input(fb_in), .cs_mv(cs_in),
        .overlap_seen(overlap));
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic close_out();
        if (n_fail == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [11:0] exp, input logic [11:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: expected %h got %h", $time, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    function automatic logic gsel(input bit lo);
        return lo ? gate_lo : gate_hi;
    endfunction
    // wait for a fresh rising edge of one gate, bounded
    task automatic rise(input bit lo);
        int k;
        k = 0;
        while (gsel(lo) !== 1'b0 && k < 20000) begin cyc(1); k++; end
        while (gsel(lo) !== 1'b1 && k < 20000) begin cyc(1); k++; end
        if (k >= 20000) chk(12'h1, 12'h0);
    endtask
    // cycles the gate stays at the given level
    task automatic width(input bit lo, input logic lvl, output logic [11:0] n);
        n = 12'h0;
        while (gsel(lo) === lvl && n < 12'hfa0) begin cyc(1); n++; end
    endtask
    task automatic on_time(input logic [11:0] exp);
        cyc(1200);
        rise(1'b0);
        width(1'b0, 1'b1, w);
        chk(exp, w);
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic s_start();
        cyc(50);
        chk(12'h0, {10'h0, gate_hi, gate_lo});
        chk(12'h5dc, fmin_hold_mv);
        supply_mv <= 16'h30d4;
        rise(1'b0);
        chk(12'h1, {11'h0, ssa});
        chk(12'h0, {11'h0, gate_lo});
        cyc(600);
        chk(12'h1, {11'h0, ssa});
        chk(12'h0, {11'h0, ovl});
        cyc(60);
        chk(12'h0, {11'h0, ssa});
        cyc(80);
        chk(12'h1, {11'h0, ovl});
    endtask
    task automatic s_freq();
        fb_mv <= 12'hf3c;
        on_time(12'h1ec);
        width(1'b1, 1'b0, w);
        chk(12'h026, w);
        width(1'b1, 1'b1, w);
        chk(12'h1ec, w);
        fb_mv <= 12'h384;
        on_time(12'h0a4);
    endtask
    task automatic s_oc();
        cs_set_mv <= 12'h384;
        cyc(1800);
        on_time(12'h063);
        fb_mv <= 12'hf3c;
        on_time(12'h07b);
        cs_set_mv <= 12'h0;
        cyc(1800);
        on_time(12'h1ec);
    endtask
    task automatic s_burst();
        int busy;
        busy = 0;
        fb_mv <= 12'h1f4;
        cyc(1100);
        repeat (300) begin cyc(1); if (gate_hi !== 1'b0 || gate_lo !== 1'b0) busy++; end
        chk(12'h0, busy[11:0]);
        fb_mv <= 12'hf3c;
        rise(1'b0);
    endtask
    task automatic s_mains();
        mains_mv <= 16'h0;
        cyc(6);
        chk(12'h0, {10'h0, gate_hi, gate_lo});
        mains_mv <= 16'h07d0;
        rise(1'b0);
        chk(12'h1, {11'h0, ssa});
    endtask
    task automatic s_latch();
        cyc(700);
        cs_set_mv <= 12'h6a4;
        cyc(3);
        chk(12'h0, {10'h0, gate_hi, gate_lo});
        chk(12'h1, {11'h0, overcurrent_protection});
        cs_set_mv <= 12'h0;
        supply_mv <= 16'h2cec;
        cyc(100);
        chk(12'h2, {10'h0, overcurrent_protection, gate_hi | gate_lo});
        supply_mv <= 16'h2904;
        cyc(6);
        chk(12'h0, {11'h0, overcurrent_protection});
        supply_mv <= 16'h30d4;
        rise(1'b0);
        chk(12'h1, {11'h0, ssa});
        chk(12'h0, {11'h0, overlap});
    endtask
    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        rst = 1'b1;
        supply_mv = 16'h2cec;
        mains_mv = 16'h07d0;
        fb_mv = 12'hfff;
        cs_set_mv = 12'h0;
        fmin_current = 12'h3e8;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        s_start();
        s_freq();
        s_oc();
        s_burst();
        s_mains();
        s_latch();
        close_out();
    end
    initial begin
        // about three times the expected run length
        #500000;
        n_fail++;
        close_out();
    end
endmodule // rhb_ctrl_bench
